// ---- hw/asc_pkg.sv ----
// Purpose: shared constants and types for association and scan setup
// Assumes: one 10 MHz clock
// Notes: command select codes are local to this block
package asc_pkg;
  localparam int CLK_KHZ = 10000;
  localparam int LOOKUP_MS = 200;
  localparam int LOOKUP_CYC = LOOKUP_MS * CLK_KHZ;
  // Per-channel dwell unit is 15.36 ms
  localparam int DWELL_US = 15360;
  localparam int DWELL_CYC = DWELL_US * CLK_KHZ / 1000;

  localparam logic [7:0] CHAN_BASE = 8'h0B;
  localparam logic [7:0] CHAN_TOP = 8'h1A;
  localparam logic [7:0] LEVEL_MAX = 8'hFF;

  localparam logic ROLE_RST = 1'b0;
  localparam logic [15:0] MASK_RST = 16'h1FFE;
  localparam logic [3:0] EXP_RST = 4'h4;
  localparam logic [3:0] MEMBER_RST = 4'h0;
  localparam logic [2:0] HUB_RST = 3'h0;

  localparam logic [15:0] ROLE_MAX = 16'h0001;
  localparam logic [15:0] EXP_MAX = 16'h000F;
  localparam logic [15:0] MEMBER_MAX = 16'h000F;
  localparam logic [15:0] HUB_MAX = 16'h0007;

  localparam int MJ_ANY_PAN = 0;
  localparam int MJ_ANY_CHAN = 1;
  localparam int MJ_AUTO = 2;
  localparam int MJ_WAKE_POLL = 3;
  localparam int HJ_FREE_PAN = 0;
  localparam int HJ_FREE_FREQ = 1;
  localparam int HJ_ACCEPT = 2;

  localparam int LABEL_CHARS = 20;
  localparam int LABEL_W = 8 * LABEL_CHARS;

  localparam logic [2:0] SEL_ROLE = 3'h0;
  localparam logic [2:0] SEL_MASK = 3'h1;
  localparam logic [2:0] SEL_EXP = 3'h2;
  localparam logic [2:0] SEL_MEMBER = 3'h3;
  localparam logic [2:0] SEL_HUB = 3'h4;

  typedef enum logic [2:0] {
    OP_READ = 3'b000,
    OP_WRITE = 3'b001,
    OP_ACTIVE = 3'b010,
    OP_ENERGY = 3'b011,
    OP_LOOKUP = 3'b100
  } asc_op_e;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_LOOKUP = 3'b001,
    ST_PROBE = 3'b010,
    ST_JOIN = 3'b011,
    ST_HUB_PAN = 3'b100,
    ST_HUB_EN = 3'b101
  } asc_state_e;
endpackage

// ---- hw/asc_scan_if.sv ----
// Purpose: carries scan requests from the sequencer to the scan timer
// Assumes: both ends on ref_clk
// Notes: mask and exponent are sampled when start is taken
`timescale 1ns/10ps
interface asc_scan_if;
  logic start;
  logic [15:0] mask;
  logic [3:0] exp_val;
  logic busy;
  logic done;
  logic chan_on;
  logic [7:0] chan;
  modport ctl(output start, mask, exp_val, input busy, done, chan_on, chan);
  modport tmr(input start, mask, exp_val, output busy, done, chan_on, chan);
endinterface

// ---- hw/asc_scan_timer.sv ----
// Purpose: walks the channel mask, dwelling 2^exp units on each enabled channel
// Assumes: start is only honoured while not busy
// Notes: a disabled mask bit costs one cycle, far below one dwell unit
`timescale 1ns/10ps
module asc_scan_timer #(
  parameter int BASE_CYC = asc_pkg::DWELL_CYC
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Scan request and progress
  asc_scan_if.tmr sif
);
  import asc_pkg::*;

  logic busy_reg;
  logic done_reg;
  logic [3:0] idx_reg;
  logic [15:0] mask_reg;
  logic [3:0] exp_reg;
  logic [17:0] base_reg;
  logic [15:0] rep_reg;

  wire cur_on = mask_reg[idx_reg];
  wire last_idx = idx_reg == 4'hF;
  wire tick = base_reg == 18'(BASE_CYC - 1);
  wire [16:0] reps = 17'h1 << exp_reg;
  wire rep_last = {1'b0, rep_reg} == reps - 17'h1;
  wire dwell_end = !cur_on || (tick && rep_last);

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
      idx_reg <= 4'h0;
      mask_reg <= 16'h0000;
      exp_reg <= 4'h0;
      base_reg <= 18'h0;
      rep_reg <= 16'h0;
    end else begin
      done_reg <= 1'b0;
      if (!busy_reg && sif.start) begin
        busy_reg <= 1'b1;
        idx_reg <= 4'h0;
        mask_reg <= sif.mask;
        exp_reg <= sif.exp_val;
        base_reg <= 18'h0;
        rep_reg <= 16'h0;
      end else if (busy_reg) begin
        base_reg <= (tick || dwell_end) ? 18'h0 : base_reg + 18'h1;
        if (dwell_end) begin
          rep_reg <= 16'h0;
          if (last_idx) begin
            busy_reg <= 1'b0;
            done_reg <= 1'b1;
          end else begin
            idx_reg <= idx_reg + 4'h1;
          end
        end else if (tick) begin
          rep_reg <= rep_reg + 16'h1;
        end
      end
    end
  end

  assign sif.busy = busy_reg;
  assign sif.done = done_reg;
  assign sif.chan_on = busy_reg && cur_on;
  assign sif.chan = CHAN_BASE + {4'h0, idx_reg};

  chan_range_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    busy_reg |-> (sif.chan >= CHAN_BASE && sif.chan <= CHAN_TOP))
    else $error("scan channel out of range");

  dwell_hold_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    busy_reg && cur_on && !(tick && rep_last) |=> idx_reg == $past(idx_reg))
    else $error("channel left before its dwell ended");

  dwell_step_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    busy_reg && dwell_end && !last_idx
      |=> busy_reg && idx_reg == $past(idx_reg) + 4'h1)
    else $error("channel did not advance after dwell");
endmodule // asc_scan_timer

// ---- hw/asc_top.sv ----
// Purpose: association and scan configuration with node-label lookup
// Assumes: command, radio and scan inputs are on ref_clk; wake_pin is not
// Notes: one command at a time; cmd_ready low while any job runs
`timescale 1ns/10ps
module asc_top #(
  parameter int LOOKUP_LIM = asc_pkg::LOOKUP_CYC,
  parameter int DWELL_LIM = asc_pkg::DWELL_CYC
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Host commands
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire asc_pkg::asc_op_e cmd_op,
  input wire logic [2:0] cmd_sel,
  input wire logic [15:0] cmd_wdata,
  input wire logic [asc_pkg::LABEL_W-1:0] label_data,
  input wire logic [4:0] label_len,
  // Host answers
  output logic rsp_valid,
  output logic rsp_ok,
  output logic [15:0] rsp_data,
  output logic cmd_mode_exit,
  // Lookup replies from remote nodes
  output logic lookup_query,
  input wire logic reply_valid,
  input wire logic [asc_pkg::LABEL_W-1:0] reply_label,
  input wire logic [63:0] reply_addr,
  output logic [31:0] target_address_high,
  output logic [31:0] target_address_low,
  // Scan progress
  output logic scan_busy,
  output logic scan_energy,
  output logic scan_chan_on,
  output logic [7:0] scan_channel,
  // Network settings and radio observations
  input wire logic [15:0] network_pan_number,
  input wire logic [7:0] radio_frequency_slot,
  input wire logic beacon_mode,
  input wire logic cand_valid,
  input wire logic [15:0] cand_pan,
  input wire logic [7:0] cand_chan,
  input wire logic join_success,
  input wire logic energy_valid,
  input wire logic [7:0] energy_level,
  // Association results
  output logic coordinator_role,
  output logic join_request,
  output logic joined,
  output logic hub_started,
  output logic [15:0] hub_pan,
  output logic [7:0] hub_channel,
  output logic accept_joiners,
  // Wake pin and poll
  input wire logic wake_pin,
  output logic poll_request
);
  import asc_pkg::*;

  // Compare only the characters the host supplied
  function automatic logic [LABEL_W-1:0] len_mask(input logic [4:0] len);
    logic [LABEL_W-1:0] m;
    m = '0;
    for (int i = 0; i < LABEL_CHARS; i++) begin
      if (i < int'(len)) begin
        m[8*i +: 8] = 8'hFF;
      end
    end
    return m;
  endfunction

  asc_scan_if sif();

  asc_scan_timer #(.BASE_CYC(DWELL_LIM)) u_timer (
    .ref_clk(ref_clk),
    .rst(rst),
    .sif(sif)
  );

  asc_state_e state_reg;
  logic role_reg;
  logic [15:0] mask_reg;
  logic [3:0] exp_reg;
  logic [3:0] member_reg;
  logic [2:0] hub_reg;
  logic [LABEL_W-1:0] label_reg;
  logic [4:0] len_reg;
  logic [20:0] lk_cnt_reg;
  logic rsp_valid_reg;
  logic rsp_ok_reg;
  logic [15:0] rsp_data_reg;
  logic exit_reg;
  logic query_reg;
  logic [31:0] addr_hi_reg;
  logic [31:0] addr_lo_reg;
  logic energy_reg;
  logic joined_reg;
  logic started_reg;
  logic join_req_reg;
  logic [15:0] hub_pan_reg;
  logic [7:0] hub_chan_reg;
  logic [7:0] best_reg;
  logic poll_reg;
  logic wake_s1_reg;
  logic wake_s2_reg;
  logic wake_s3_reg;

  wire idle = state_reg == ST_IDLE;
  wire take = cmd_valid && idle;
  wire is_wr = take && cmd_op == OP_WRITE;
  wire is_rd = take && cmd_op == OP_READ;
  wire is_probe = take && (cmd_op == OP_ACTIVE || cmd_op == OP_ENERGY);
  wire is_lookup = take && cmd_op == OP_LOOKUP;
  wire empty_arg = is_lookup && label_len == 5'h0;

  wire hit = state_reg == ST_LOOKUP && reply_valid
    && ((reply_label ^ label_reg) & len_mask(len_reg)) == '0;
  wire lk_tout = state_reg == ST_LOOKUP && !hit
    && lk_cnt_reg == 21'(LOOKUP_LIM - 1);

  // Background jobs only start when no host command is offered
  wire join_go = idle && !cmd_valid && !role_reg && !joined_reg
    && (member_reg[MJ_AUTO] || beacon_mode);
  wire hub_go = idle && !cmd_valid && role_reg && !started_reg;
  wire hub_pan_go = hub_go && hub_reg[HJ_FREE_PAN];
  wire hub_en_go = (hub_go && !hub_reg[HJ_FREE_PAN]
    && hub_reg[HJ_FREE_FREQ])
    || (state_reg == ST_HUB_PAN && sif.done
    && hub_reg[HJ_FREE_FREQ]);

  wire pan_ok = member_reg[MJ_ANY_PAN]
    || cand_pan == network_pan_number;
  wire chan_ok = member_reg[MJ_ANY_CHAN]
    || cand_chan == radio_frequency_slot;
  wire wake_rise = wake_s2_reg && !wake_s3_reg;

  wire wr_bad = (cmd_sel == SEL_ROLE && cmd_wdata > ROLE_MAX)
    || (cmd_sel == SEL_EXP && cmd_wdata > EXP_MAX)
    || (cmd_sel == SEL_MEMBER && cmd_wdata > MEMBER_MAX)
    || (cmd_sel == SEL_HUB && cmd_wdata > HUB_MAX)
    || cmd_sel > SEL_HUB;
  wire [15:0] rd_val =
    cmd_sel == SEL_ROLE ? {15'h0, role_reg} :
    cmd_sel == SEL_MASK ? mask_reg :
    cmd_sel == SEL_EXP ? {12'h0, exp_reg} :
    cmd_sel == SEL_MEMBER ? {12'h0, member_reg} :
    cmd_sel == SEL_HUB ? {13'h0, hub_reg} : 16'h0000;

  assign sif.start = is_probe || join_go || hub_pan_go || hub_en_go;
  assign sif.mask = mask_reg;
  assign sif.exp_val = exp_reg;

  // Settings; reserved bits are never stored
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      role_reg <= ROLE_RST;
      mask_reg <= MASK_RST;
      exp_reg <= EXP_RST;
      member_reg <= MEMBER_RST;
      hub_reg <= HUB_RST;
    end else if (is_wr && !wr_bad) begin
      if (cmd_sel == SEL_ROLE) role_reg <= cmd_wdata[0];
      if (cmd_sel == SEL_MASK) mask_reg <= cmd_wdata;
      if (cmd_sel == SEL_EXP) exp_reg <= cmd_wdata[3:0];
      if (cmd_sel == SEL_MEMBER) member_reg <= cmd_wdata[3:0];
      if (cmd_sel == SEL_HUB) hub_reg <= cmd_wdata[2:0];
    end
  end

  // Wake pin synchroniser and edge
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wake_s1_reg <= 1'b0;
      wake_s2_reg <= 1'b0;
      wake_s3_reg <= 1'b0;
      poll_reg <= 1'b0;
    end else begin
      wake_s1_reg <= wake_pin;
      wake_s2_reg <= wake_s1_reg;
      wake_s3_reg <= wake_s2_reg;
      poll_reg <= wake_rise && !role_reg && member_reg[MJ_WAKE_POLL];
    end
  end

  // Sequencer, answers and association state
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      label_reg <= '0;
      len_reg <= 5'h0;
      lk_cnt_reg <= 21'h0;
      rsp_valid_reg <= 1'b0;
      rsp_ok_reg <= 1'b0;
      rsp_data_reg <= 16'h0000;
      exit_reg <= 1'b0;
      query_reg <= 1'b0;
      addr_hi_reg <= 32'h0;
      addr_lo_reg <= 32'h0;
      energy_reg <= 1'b0;
      joined_reg <= 1'b0;
      started_reg <= 1'b0;
      join_req_reg <= 1'b0;
      hub_pan_reg <= 16'h0000;
      hub_chan_reg <= 8'h00;
      best_reg <= LEVEL_MAX;
    end else begin
      rsp_valid_reg <= 1'b0;
      exit_reg <= 1'b0;
      query_reg <= 1'b0;
      join_req_reg <= 1'b0;
      lk_cnt_reg <= state_reg == ST_LOOKUP ? lk_cnt_reg + 21'h1 : 21'h0;
      if (is_wr && !wr_bad && cmd_sel == SEL_ROLE) begin
        started_reg <= 1'b0;
      end
      // A join report beats a role write in the same cycle
      if (!role_reg && join_success) begin
        joined_reg <= 1'b1;
      end else if (is_wr && !wr_bad && cmd_sel == SEL_ROLE) begin
        joined_reg <= 1'b0;
      end
      case (state_reg)
        ST_IDLE: begin
          if (is_rd || is_wr || empty_arg) begin
            rsp_valid_reg <= 1'b1;
            rsp_ok_reg <= is_rd || (is_wr && !wr_bad);
            rsp_data_reg <= is_rd ? rd_val : 16'h0000;
          end else if (is_lookup) begin
            label_reg <= label_data;
            len_reg <= label_len;
            query_reg <= 1'b1;
            state_reg <= ST_LOOKUP;
          end else if (is_probe) begin
            energy_reg <= cmd_op == OP_ENERGY;
            state_reg <= ST_PROBE;
          end else if (join_go) begin
            energy_reg <= 1'b0;
            state_reg <= ST_JOIN;
          end else if (hub_go) begin
            hub_pan_reg <= network_pan_number;
            hub_chan_reg <= radio_frequency_slot;
            best_reg <= LEVEL_MAX;
            energy_reg <= !hub_reg[HJ_FREE_PAN];
            if (hub_pan_go) state_reg <= ST_HUB_PAN;
            else if (hub_en_go) state_reg <= ST_HUB_EN;
            else started_reg <= 1'b1;
          end
        end
        ST_LOOKUP: begin
          if (hit) begin
            addr_hi_reg <= reply_addr[63:32];
            addr_lo_reg <= reply_addr[31:0];
            rsp_valid_reg <= 1'b1;
            rsp_ok_reg <= 1'b1;
            rsp_data_reg <= 16'h0000;
            exit_reg <= 1'b1;
            state_reg <= ST_IDLE;
          end else if (lk_tout) begin
            rsp_valid_reg <= 1'b1;
            rsp_ok_reg <= 1'b0;
            rsp_data_reg <= 16'h0000;
            state_reg <= ST_IDLE;
          end
        end
        ST_PROBE: begin
          if (sif.done) begin
            rsp_valid_reg <= 1'b1;
            rsp_ok_reg <= 1'b1;
            rsp_data_reg <= 16'h0000;
            state_reg <= ST_IDLE;
          end
        end
        ST_JOIN: begin
          if (cand_valid && sif.chan_on && pan_ok && chan_ok) begin
            join_req_reg <= 1'b1;
          end
          // Stay until the timer stops so a later scan starts clean
          if (sif.done) state_reg <= ST_IDLE;
        end
        ST_HUB_PAN: begin
          if (cand_valid && cand_pan == hub_pan_reg) begin
            hub_pan_reg <= hub_pan_reg + 16'h1;
          end
          if (sif.done && hub_en_go) begin
            energy_reg <= 1'b1;
            state_reg <= ST_HUB_EN;
          end else if (sif.done) begin
            started_reg <= 1'b1;
            state_reg <= ST_IDLE;
          end
        end
        ST_HUB_EN: begin
          if (energy_valid && sif.chan_on && energy_level < best_reg) begin
            best_reg <= energy_level;
            hub_chan_reg <= sif.chan;
          end
          if (sif.done) begin
            started_reg <= 1'b1;
            state_reg <= ST_IDLE;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  assign cmd_ready = idle;
  assign rsp_valid = rsp_valid_reg;
  assign rsp_ok = rsp_ok_reg;
  assign rsp_data = rsp_data_reg;
  assign cmd_mode_exit = exit_reg;
  assign lookup_query = query_reg;
  assign target_address_high = addr_hi_reg;
  assign target_address_low = addr_lo_reg;
  assign scan_busy = sif.busy;
  assign scan_energy = energy_reg;
  assign scan_chan_on = sif.chan_on;
  assign scan_channel = sif.chan;
  assign coordinator_role = role_reg;
  assign join_request = join_req_reg;
  assign joined = joined_reg;
  assign hub_started = started_reg;
  assign hub_pan = hub_pan_reg;
  assign hub_channel = hub_chan_reg;
  assign accept_joiners = role_reg && hub_reg[HJ_ACCEPT];
  assign poll_request = poll_reg;

  lookup_ok_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    hit |=> rsp_valid && rsp_ok && cmd_mode_exit
      && target_address_low == $past(reply_addr[31:0]))
    else $error("lookup hit not answered");

  lookup_tout_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    lk_tout |=> rsp_valid && !rsp_ok && !cmd_mode_exit && cmd_ready)
    else $error("lookup timeout not reported");

  empty_arg_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    empty_arg |=> rsp_valid && !rsp_ok && cmd_ready)
    else $error("empty lookup not refused");

  exp_range_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    is_wr && cmd_sel == SEL_EXP && cmd_wdata > EXP_MAX
      |=> !rsp_ok && exp_reg == $past(exp_reg))
    else $error("exponent accepted out of range");

  rsvd_zero_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    is_rd && (cmd_sel == SEL_MEMBER || cmd_sel == SEL_HUB)
      |=> rsp_data[15:4] == 12'h000 && (rsp_data[3] == 1'b0
      || $past(cmd_sel) == SEL_MEMBER))
    else $error("reserved option bits not zero");

  join_match_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    join_request |-> $past(pan_ok) && $past(chan_ok))
    else $error("join to mismatched coordinator");

  auto_join_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    state_reg == ST_JOIN |-> !role_reg
      && (member_reg[MJ_AUTO] || beacon_mode))
    else $error("join scan without auto join");

  wake_poll_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    wake_rise && !role_reg && member_reg[MJ_WAKE_POLL]
      |=> poll_request ##1 !poll_request)
    else $error("pin wake poll missing");

  hub_scan_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    state_reg == ST_HUB_PAN |-> role_reg && hub_reg[HJ_FREE_PAN]
      && sif.busy || sif.done)
    else $error("network scan without free pan choice");
endmodule // asc_top

// ---- dv/asc_node_model.sv ----
// Purpose: remote node that answers label lookups from the block
// Assumes: one reply burst per query, bench sets label and address
// Notes: a decoy with a different first character precedes the answer
`timescale 1ns/10ps
module asc_node_model (
  // Clock
  input wire logic ref_clk,
  // Query from the block
  input wire logic lookup_query,
  // Behaviour chosen by the bench
  input wire logic answer_en,
  input wire logic [7:0] delay,
  input wire logic [159:0] node_label,
  input wire logic [63:0] node_addr,
  // Reply to the block
  output logic reply_valid,
  output logic [159:0] reply_label,
  output logic [63:0] reply_addr
);
  logic [8:0] cnt = '0;
  initial begin
    reply_valid = 1'b0;
    reply_label = '0;
    reply_addr = '0;
  end
  // Idle lines toggle so a stale label can never look like a match
  always @(posedge ref_clk) begin
    reply_valid <= 1'b0;
    reply_label <= ~reply_label;
    reply_addr <= ~reply_addr;
    if (cnt != 9'h0) cnt <= cnt - 9'h1;
    if (lookup_query === 1'b1 && answer_en) cnt <= {1'b0, delay} + 9'h2;
    if (cnt == 9'h2) begin
      reply_valid <= 1'b1;
      reply_label <= node_label ^ 160'h1;
      reply_addr <= ~node_addr;
    end
    if (cnt == 9'h1) begin
      reply_valid <= 1'b1;
      reply_label <= node_label;
      reply_addr <= node_addr;
    end
  end
endmodule // asc_node_model

// ---- dv/association_scan_config_tb_top.sv ----
// Purpose: self-checking bench for the association and scan block
// Assumes: short lookup and dwell limits stand in for the real ones
// Notes: answers are matched in order against a queue of notes
`timescale 1ns/10ps
module association_scan_config_tb_top;
  import asc_pkg::*;
  localparam int LK = 50;
  localparam int DW = 2;
  localparam logic [15:0] RV [5] = '{16'(ROLE_RST), MASK_RST,
    16'(EXP_RST), 16'(MEMBER_RST), 16'(HUB_RST)};
  localparam logic [2:0] WS [9] = '{SEL_ROLE, SEL_ROLE, SEL_EXP, SEL_EXP,
    SEL_MEMBER, SEL_MEMBER, SEL_HUB, SEL_HUB, 3'h5};
  localparam logic [15:0] WV [9] = '{16'h1, 16'h2, 16'hF, 16'h10, 16'hF,
    16'h10, 16'h7, 16'h8, 16'h0};
  typedef struct {logic ok; logic [15:0] d; logic ex;} asc_note_s;
  asc_note_s notes[$];
  int checks = 0;
  int bad_count = 0;
  int busy_cyc = 0;
  int polls = 0;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic cmd_valid = 1'b0;
  asc_op_e cmd_op = OP_READ;
  logic [2:0] cmd_sel = '0;
  logic [15:0] cmd_wdata = '0;
  logic [159:0] label_data = '0;
  logic [4:0] label_len = '0;
  logic [63:0] addr = '0;
  logic [7:0] dly = '0;
  logic answer_en = 1'b0;
  logic [15:0] network_pan_number = '0;
  logic [7:0] radio_frequency_slot = '0;
  logic beacon_mode = 1'b0;
  logic join_success = 1'b0;
  logic cand_valid = 1'b0;
  logic energy_valid = 1'b0;
  logic [15:0] cand_pan = '0;
  logic [7:0] cand_chan = '0;
  logic [7:0] energy_level = '0;
  logic wake_pin = 1'b0;
  logic [15:0] mask = MASK_RST;
  logic [1:0] fix_cand = 2'h0;
  logic [7:0] best = LEVEL_MAX;
  logic [7:0] bchan = '0;
  int reqs = 0;
  logic cmd_ready, rsp_valid, rsp_ok, cmd_mode_exit, lookup_query;
  logic reply_valid, scan_busy, scan_energy, scan_chan_on;
  logic coordinator_role, join_request, joined, hub_started;
  logic accept_joiners, poll_request;
  logic [15:0] rsp_data, hub_pan;
  logic [159:0] reply_label;
  logic [63:0] reply_addr;
  logic [31:0] target_address_high, target_address_low;
  logic [7:0] scan_channel, hub_channel;

  asc_top #(.LOOKUP_LIM(LK), .DWELL_LIM(DW)) dut (.ref_clk, .rst,
    .cmd_valid, .cmd_ready, .cmd_op, .cmd_sel, .cmd_wdata, .label_data,
    .label_len, .rsp_valid, .rsp_ok, .rsp_data, .cmd_mode_exit,
    .lookup_query, .reply_valid, .reply_label, .reply_addr,
    .target_address_high, .target_address_low, .scan_busy, .scan_energy,
    .scan_chan_on, .scan_channel, .network_pan_number,
    .radio_frequency_slot, .beacon_mode, .cand_valid, .cand_pan,
    .cand_chan, .join_success, .energy_valid, .energy_level,
    .coordinator_role, .join_request, .joined, .hub_started, .hub_pan,
    .hub_channel, .accept_joiners, .wake_pin, .poll_request);

  asc_node_model node (.ref_clk, .lookup_query, .answer_en, .delay(dly),
    .node_label(label_data ^ ({160{1'b1}} << (8 * label_len))),
    .node_addr(addr), .reply_valid, .reply_label, .reply_addr);

  always #50 ref_clk = ~ref_clk;

  task automatic cmp(string n, logic [63:0] e, logic [63:0] g);
    checks++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // Waits for the answer too, so callers see settled results
  task automatic cmd(asc_op_e op, logic [2:0] sel, logic [15:0] wd,
      logic ok, logic [15:0] d, logic ex);
    int n;
    n = 0;
    @(negedge ref_clk);
    cmd_valid = 1'b1;
    cmd_op = op;
    cmd_sel = sel;
    cmd_wdata = wd;
    notes.push_back('{ok, d, ex});
    while (cmd_ready !== 1'b1) @(negedge ref_clk);
    @(negedge ref_clk);
    cmd_valid = 1'b0;
    while ((notes.size() != 0 || cmd_ready !== 1'b1) && n < 4000) begin
      @(negedge ref_clk);
      n++;
    end
    if (n >= 4000) cmp("answer wait", 0, 1);
  endtask

  // Fixed candidates: 1 matches the settings, 2 misses pan and channel
  always @(negedge ref_clk) begin
    logic [33:0] r;
    r = 34'({$urandom, $urandom});
    if (fix_cand != 2'h0)
      r[33:8] = {2'b11, network_pan_number + 16'(fix_cand - 2'h1),
        radio_frequency_slot + 8'(fix_cand - 2'h1)};
    // Lowest reading on an enabled channel, first one wins
    if (scan_chan_on === 1'b1 && scan_energy === 1'b1 && r[32]
        && coordinator_role === 1'b1 && r[7:0] < best) begin
      best = r[7:0];
      bchan = scan_channel;
    end
    {cand_valid, energy_valid, cand_pan, cand_chan, energy_level} <= r;
    if (scan_busy === 1'b1) busy_cyc++;
    if (poll_request === 1'b1) polls++;
    if (join_request === 1'b1) reqs++;
    if (scan_chan_on === 1'b1)
      cmp("chan enabled", 1, mask[scan_channel - CHAN_BASE]);
    if (rsp_valid === 1'b1) begin
      if (notes.size() == 0) cmp("spare answer", 0, 1);
      else begin
        cmp("rsp_ok", notes[0].ok, rsp_ok);
        cmp("rsp_data", notes[0].d, rsp_data);
        cmp("mode exit", notes[0].ex, cmd_mode_exit);
        void'(notes.pop_front());
      end
    end
  end

  initial begin
    #2000000;
    bad_count++;
    tally_and_finish();
  end

  initial begin
    int k;
    void'($urandom(32'h95b82299));
    network_pan_number = 16'($urandom);
    radio_frequency_slot = 8'($urandom);
    repeat (5) @(negedge ref_clk);
    rst = 1'b0;
    for (int i = 0; i < 5; i++)
      cmd(OP_READ, 3'(i), 16'h0, 1, RV[i], 0);
    $display("reset values done");
    // Role 1 first: option writes then start no scans behind our back
    for (int i = 0; i < 9; i++)
      cmd(OP_WRITE, WS[i], WV[i], i % 2 == 0 && i < 8, 0, 0);
    for (int i = 0; i < 8; i += 2)
      cmd(OP_READ, WS[i], 16'h0, 1, WV[i], 0);
    cmp("role", 1, coordinator_role);
    cmp("started", 1, hub_started);
    cmp("hub pan", network_pan_number, hub_pan);
    cmp("hub chan", radio_frequency_slot, hub_channel);
    cmp("accept", 1, accept_joiners);
    cmd(OP_WRITE, SEL_HUB, 16'h3, 1, 0, 0);
    cmp("accept", 0, accept_joiners);
    $display("settings done");
    cmd(OP_WRITE, SEL_EXP, 16'h1, 1, 0, 0);
    cmd(OP_WRITE, SEL_MEMBER, 16'h8, 1, 0, 0);
    cmd(OP_WRITE, SEL_ROLE, 16'h0, 1, 0, 0);
    for (int m = 0; m < 2; m++) begin
      if (m == 1) cmd(OP_WRITE, SEL_MEMBER, 16'h0, 1, 0, 0);
      polls = 0;
      wake_pin = 1'b1;
      repeat (8) @(negedge ref_clk);
      wake_pin = 1'b0;
      repeat (4) @(negedge ref_clk);
      cmp("poll count", 1 - m, polls);
    end
    $display("wake poll done");
    mask = (16'($urandom) & 16'h3FFE) | 16'h0002;
    cmd(OP_WRITE, SEL_MASK, mask, 1, 0, 0);
    cmd(OP_READ, SEL_MASK, 16'h0, 1, mask, 0);
    k = $countones(mask);
    for (int s = 0; s < 2; s++) begin
      busy_cyc = 0;
      cmd(s ? OP_ENERGY : OP_ACTIVE, 3'h0, 16'h0, 1, 0, 0);
      cmp("scan cycles", k * 2 * DW + 16 - k, busy_cyc);
      cmp("energy flag", s, scan_energy);
    end
    $display("scan done");
    for (int p = 0; p < 3; p++) begin
      fix_cand = (p == 1) ? 2'h1 : 2'h2;
      cmd(OP_WRITE, SEL_MEMBER, (p == 2) ? 16'h7 : 16'h4, 1, 0, 0);
      reqs = 0;
      repeat (120) @(negedge ref_clk);
      cmp("join requests", p != 0, reqs > 0);
    end
    join_success = 1'b1;
    @(negedge ref_clk);
    join_success = 1'b0;
    cmp("joined", 1, joined);
    $display("join done");
    fix_cand = 2'h1;
    best = LEVEL_MAX;
    bchan = radio_frequency_slot;
    cmd(OP_WRITE, SEL_ROLE, 16'h1, 1, 0, 0);
    cmd(OP_READ, SEL_HUB, 16'h0, 1, 16'h3, 0);
    cmp("hub pan", 16'(network_pan_number + 16'h1), hub_pan);
    cmp("hub chan", bchan, hub_channel);
    cmp("hub started", 1, hub_started);
    cmp("joined", 0, joined);
    $display("hub done");
    for (int t = 0; t < 3; t++) begin
      label_data = {$urandom, $urandom, $urandom, $urandom, $urandom};
      addr = {$urandom, $urandom};
      dly = 8'($urandom % 20);
      label_len = (t == 1) ? 5'h0 : 5'(1 + $urandom % 20);
      answer_en = (t != 2);
      cmd(OP_LOOKUP, 3'h0, 16'h0, t == 0, 16'h0, t == 0);
      if (t == 0) begin
        cmp("addr high", addr[63:32], target_address_high);
        cmp("addr low", addr[31:0], target_address_low);
      end
    end
    $display("lookup done");
    tally_and_finish();
  end
endmodule // association_scan_config_tb_top
